//--- verilog/mmg_regs.v
// Purpose: Medium, monitor, pin and soft reset register bank over AXI4-Lite
// Assumes: PHY address word and link rate come from outside as levels
// Notes: Control outputs are registered from register bits, backpressure and PHY resets also from inputs
//
// Contract
// [RULE1] Read-only PHY address word from EEPROM word
// [RULE2] full_duplex one selects full duplex
// [RULE3] rx_pause_enable lets MAC obey pause frames
// [RULE4] tx_pause_enable allows sending pause frames
// [RULE5] pause_by_type_only matches length/type alone
// [RULE6] rx_path_on gates reception, off at reset
// [RULE7] mii_speed_select one gives 100 Mbps
// [RULE8] Half duplex backpressure, continuous or intermittent
// [RULE9] fast_backoff shortens collision back-off
// [RULE10] Software keeps fixed medium mode bits
// [RULE11] monitor_only checks frames but stores none
// [RULE12] Wake on link and magic, off at reset
// [RULE13] Monitor status returns enables and link rate
// [RULE14] Pin status shows enables and input levels
// [RULE15] Enabled pin drives written value, else input
// [RULE16] eeprom_reload starts configuration reload
// [RULE17] Error clear bits hold errors cleared
// [RULE18] Tristate bit floats external PHY reset
// [RULE19] Selected level drives external PHY reset
// [RULE20] force_zero_length returns zero-length bulk-in
// [RULE21] int_phy_run releases internal PHY reset
// [RULE22] int_phy_powerdown powers internal PHY down
// [RULE23] Status addresses return last written control; pin status returns input levels, not drive values
`timescale 1ns/1ps
`default_nettype none
`include "mmg_defines.vh"
module mmg_regs #(
  parameter AW   = 8,
  parameter NPIN = 3
) (
  input  wire            aclk,
  input  wire            aresetn,
  input  wire [AW-1:0]   s_axi_awaddr,
  input  wire            s_axi_awvalid,
  output wire            s_axi_awready,
  input  wire [31:0]     s_axi_wdata,
  input  wire [3:0]      s_axi_wstrb,
  input  wire            s_axi_wvalid,
  output wire            s_axi_wready,
  output wire [1:0]      s_axi_bresp,
  output wire            s_axi_bvalid,
  input  wire            s_axi_bready,
  input  wire [AW-1:0]   s_axi_araddr,
  input  wire            s_axi_arvalid,
  output wire            s_axi_arready,
  output wire [31:0]     s_axi_rdata,
  output wire [1:0]      s_axi_rresp,
  output wire            s_axi_rvalid,
  input  wire            s_axi_rready,
  input  wire [2:0]      secondary_phy_kind,
  input  wire [4:0]      secondary_phy_index,
  input  wire [2:0]      primary_phy_kind,
  input  wire [4:0]      primary_phy_index,
  input  wire            link_rate_high,
  input  wire            reset_ctrl_select,
  input  wire            usb_reset_level,
  input  wire            half_duplex_rx_full,
  input  wire [NPIN-1:0] pin_in,
  output wire [NPIN-1:0] pin_out,
  output wire [NPIN-1:0] pin_oe,
  output reg             full_duplex,
  output reg             rx_pause_enable,
  output reg             tx_pause_enable,
  output reg             pause_by_type_only,
  output reg             rx_path_on,
  output reg             mii_speed_select,
  output reg             backpressure_continuous,
  output reg             fast_backoff,
  output reg             backpressure_on,
  output reg             monitor_only,
  output reg             wake_on_link,
  output reg             wake_on_magic,
  output reg             eeprom_reload,
  output reg             bulkin_error_clear,
  output reg             bulkout_error_clear,
  output reg             force_zero_length,
  output reg             int_phy_reset_n,
  output reg             int_phy_powerdown,
  output reg             ext_phy_reset_pin_out,
  output reg             ext_phy_reset_pin_oe
);
  wire          wr_en;
  wire [AW-1:0] wr_addr;
  wire [31:0]   wr_data;
  wire [3:0]    wr_strb;
  wire [AW-1:0] rd_addr;
  reg  [31:0]   rd_data;
  reg           rd_ok;
  reg           wr_ok;
  wire [2*NPIN-1:0] pin_status;

  reg  [15:0]   med_mode_reg;
  reg  [15:0]   med_mode_next;
  reg  [7:0]    mon_ctrl_reg;
  reg  [7:0]    mon_ctrl_next;
  reg  [7:0]    pin_ctrl_reg;
  reg  [7:0]    pin_ctrl_next;
  reg  [7:0]    soft_rst_reg;
  reg  [7:0]    soft_rst_next;
  reg  [NPIN-1:0] drv_en;
  reg  [NPIN-1:0] drv_val;
  integer       k;

  // Register index from a word-aligned byte address
  function [AW-1:0] word_index;
    input [AW-1:0] addr;
    begin
      word_index = {2'b00, addr[AW-1:2]};
    end
  endfunction

  // Byte-lane merge of a write into a stored value
  function [15:0] merge16;
    input [15:0] old;
    input [15:0] data;
    input [1:0]  strb;
    begin
      merge16[7:0]  = strb[0] ? data[7:0]  : old[7:0];
      merge16[15:8] = strb[1] ? data[15:8] : old[15:8];
    end
  endfunction

  mmg_axil_slave #(
    .AW (AW)
  ) u_bus (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .s_awaddr  (s_axi_awaddr),
    .s_awvalid (s_axi_awvalid),
    .s_awready (s_axi_awready),
    .s_wdata   (s_axi_wdata),
    .s_wstrb   (s_axi_wstrb),
    .s_wvalid  (s_axi_wvalid),
    .s_wready  (s_axi_wready),
    .s_bresp   (s_axi_bresp),
    .s_bvalid  (s_axi_bvalid),
    .s_bready  (s_axi_bready),
    .s_araddr  (s_axi_araddr),
    .s_arvalid (s_axi_arvalid),
    .s_arready (s_axi_arready),
    .s_rdata   (s_axi_rdata),
    .s_rresp   (s_axi_rresp),
    .s_rvalid  (s_axi_rvalid),
    .s_rready  (s_axi_rready),
    .wr_en     (wr_en),
    .wr_addr   (wr_addr),
    .wr_data   (wr_data),
    .wr_strb   (wr_strb),
    .wr_ok     (wr_ok),
    .rd_addr   (rd_addr),
    .rd_data   (rd_data),
    .rd_ok     (rd_ok)
  );

  // Pin fields unpacked from the pin control register
  always @* begin
    drv_en  = {NPIN{1'b0}};
    drv_val = {NPIN{1'b0}};
    for (k = 0; k < NPIN; k = k + 1) begin
      drv_en[k]  = pin_ctrl_reg[2*k];
      drv_val[k] = pin_ctrl_reg[2*k+1];
    end
  end

  mmg_pin_bank #(
    .NPIN (NPIN)
  ) u_pins (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .drive_enable (drv_en),
    .drive_value  (drv_val),
    .pin_in       (pin_in),
    .pin_out      (pin_out),
    .pin_oe       (pin_oe),
    .pin_status   (pin_status)
  );

  // Write decode, only write-only indices accept data
  always @* begin
    med_mode_next = med_mode_reg;
    mon_ctrl_next = mon_ctrl_reg;
    pin_ctrl_next = pin_ctrl_reg;
    soft_rst_next = soft_rst_reg;
    wr_ok         = 1'b1;
    case (word_index(wr_addr))
      `MMG_IDX_MED_MODE: begin
        // Fixed bits are forced so a careless write cannot upset the MAC [RULE10]
        med_mode_next = (merge16(med_mode_reg, wr_data[15:0], wr_strb[1:0])
                         & `MMG_MED_MODE_MASK) | `MMG_MED_MODE_FIXED;
      end
      `MMG_IDX_MON_CTRL: begin
        if (wr_strb[0]) begin
          mon_ctrl_next = wr_data[7:0] & `MMG_MON_CTRL_MASK; // [RULE12]
        end
      end
      `MMG_IDX_PIN_CTRL: begin
        if (wr_strb[0]) begin
          pin_ctrl_next = wr_data[7:0] & `MMG_PIN_CTRL_MASK;
        end
      end
      `MMG_IDX_SOFT_RST: begin
        if (wr_strb[0]) begin
          soft_rst_next = wr_data[7:0] & `MMG_SOFT_RST_MASK;
        end
      end
      default: begin
        wr_ok = 1'b0;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      med_mode_reg <= `MMG_MED_MODE_RST;
      mon_ctrl_reg <= `MMG_MON_CTRL_RST;
      pin_ctrl_reg <= `MMG_PIN_CTRL_RST;
      soft_rst_reg <= `MMG_SOFT_RST_RST;
    end else if (wr_en) begin
      med_mode_reg <= med_mode_next;
      mon_ctrl_reg <= mon_ctrl_next;
      pin_ctrl_reg <= pin_ctrl_next;
      soft_rst_reg <= soft_rst_next;
    end
  end

  // Read decode, medium and monitor status echo their paired control
  always @* begin
    rd_data = 32'h00000000;
    rd_ok   = 1'b1;
    case (word_index(rd_addr))
      `MMG_IDX_PHY_ADDR: begin
        rd_data[15:0] = {primary_phy_kind, primary_phy_index,
                         secondary_phy_kind, secondary_phy_index}; // [RULE1]
      end
      `MMG_IDX_MED_STATUS: begin
        rd_data[15:0] = med_mode_reg; // [RULE23]
      end
      `MMG_IDX_MON_STATUS: begin
        rd_data[7:0] = mon_ctrl_reg; // [RULE13] [RULE23]
        rd_data[`MMG_MON_RATE] = link_rate_high; // [RULE13]
      end
      `MMG_IDX_PIN_STATUS: begin
        rd_data[2*NPIN-1:0] = pin_status; // [RULE14]
      end
      default: begin
        rd_ok = 1'b0;
      end
    endcase
  end

  // Control outputs decoded from the stored registers
  always @(posedge aclk) begin
    if (!aresetn) begin
      full_duplex             <= 1'b1;
      rx_pause_enable         <= 1'b1;
      tx_pause_enable         <= 1'b1;
      pause_by_type_only      <= 1'b0;
      rx_path_on              <= 1'b0;
      mii_speed_select        <= 1'b1;
      backpressure_continuous <= 1'b0;
      fast_backoff            <= 1'b0;
      backpressure_on         <= 1'b0;
      monitor_only            <= 1'b0;
      wake_on_link            <= 1'b0;
      wake_on_magic           <= 1'b0;
      eeprom_reload           <= 1'b0;
      bulkin_error_clear      <= 1'b0;
      bulkout_error_clear     <= 1'b0;
      force_zero_length       <= 1'b0;
      int_phy_reset_n         <= 1'b0;
      int_phy_powerdown       <= 1'b1;
      ext_phy_reset_pin_out   <= 1'b0;
      ext_phy_reset_pin_oe    <= 1'b0;
    end else begin
      full_duplex             <= med_mode_reg[`MMG_MM_FD]; // [RULE2]
      rx_pause_enable         <= med_mode_reg[`MMG_MM_RFC]; // [RULE3]
      tx_pause_enable         <= med_mode_reg[`MMG_MM_TFC]; // [RULE4]
      pause_by_type_only      <= med_mode_reg[`MMG_MM_PF]; // [RULE5]
      rx_path_on              <= med_mode_reg[`MMG_MM_RE]; // [RULE6]
      mii_speed_select        <= med_mode_reg[`MMG_MM_PS]; // [RULE7]
      backpressure_continuous <= med_mode_reg[`MMG_MM_SBP]; // [RULE8]
      fast_backoff            <= med_mode_reg[`MMG_MM_SM]; // [RULE9]
      backpressure_on         <= !med_mode_reg[`MMG_MM_FD] && med_mode_reg[`MMG_MM_TFC]
                                 && half_duplex_rx_full; // [RULE8]
      monitor_only            <= mon_ctrl_reg[`MMG_MON_ONLY]; // [RULE11]
      wake_on_link            <= mon_ctrl_reg[`MMG_MON_LINK]; // [RULE12]
      wake_on_magic           <= mon_ctrl_reg[`MMG_MON_MAGIC]; // [RULE12]
      eeprom_reload           <= pin_ctrl_reg[`MMG_PIN_RELOAD]; // [RULE16]
      bulkin_error_clear      <= soft_rst_reg[`MMG_SR_BULKIN]; // [RULE17]
      bulkout_error_clear     <= soft_rst_reg[`MMG_SR_BULKOUT]; // [RULE17]
      force_zero_length       <= soft_rst_reg[`MMG_SR_ZLP]; // [RULE20]
      int_phy_reset_n         <= reset_ctrl_select ? soft_rst_reg[`MMG_SR_RUN]
                                                   : !usb_reset_level; // [RULE21]
      int_phy_powerdown       <= soft_rst_reg[`MMG_SR_PD]; // [RULE22]
      ext_phy_reset_pin_oe    <= !soft_rst_reg[`MMG_SR_TRI]; // [RULE18]
      ext_phy_reset_pin_out   <= reset_ctrl_select ? soft_rst_reg[`MMG_SR_LEVEL]
                                                   : !usb_reset_level; // [RULE19] [RULE18]
    end
  end
endmodule // mmg_regs
`default_nettype wire

//--- verilog/mmg_defines.vh
// Purpose: Offsets, field positions and reset values of the medium, monitor, pin and reset bank
// Assumes: Byte address of each register is four times its printed index
// Notes: Definitions only
`ifndef MMG_DEFINES_VH
`define MMG_DEFINES_VH

`define MMG_IDX_PHY_ADDR      8'h19
`define MMG_IDX_MED_STATUS    8'h1A
`define MMG_IDX_MED_MODE      8'h1B
`define MMG_IDX_MON_STATUS    8'h1C
`define MMG_IDX_MON_CTRL      8'h1D
`define MMG_IDX_PIN_STATUS    8'h1E
`define MMG_IDX_PIN_CTRL      8'h1F
`define MMG_IDX_SOFT_RST      8'h20

`define MMG_MED_MODE_RST      16'h0236
`define MMG_MED_MODE_MASK     16'h1BB6
`define MMG_MED_MODE_FIXED    16'h0004
`define MMG_MON_CTRL_RST      8'h00
`define MMG_MON_CTRL_MASK     8'h07
`define MMG_PIN_CTRL_RST      8'h00
`define MMG_PIN_CTRL_MASK     8'hBF
`define MMG_SOFT_RST_RST      8'h4C
`define MMG_SOFT_RST_MASK     8'h7F

`define MMG_MM_FD             1
`define MMG_MM_RFC            4
`define MMG_MM_TFC            5
`define MMG_MM_PF             7
`define MMG_MM_RE             8
`define MMG_MM_PS             9
`define MMG_MM_SBP            11
`define MMG_MM_SM             12

`define MMG_MON_ONLY          0
`define MMG_MON_LINK          1
`define MMG_MON_MAGIC         2
`define MMG_MON_RATE          4

`define MMG_PIN_RELOAD        7

`define MMG_SR_BULKIN         0
`define MMG_SR_BULKOUT        1
`define MMG_SR_TRI            2
`define MMG_SR_LEVEL          3
`define MMG_SR_ZLP            4
`define MMG_SR_RUN            5
`define MMG_SR_PD             6

`define MMG_RESP_OKAY         2'b00
`define MMG_RESP_SLVERR       2'b10

`endif

//--- verilog/mmg_axil_slave.v
// Purpose: AXI4-Lite slave handshake, one write and one read at a time
// Assumes: Address and data may arrive in either order
// Notes: Raises wr_en for one cycle once both halves are held
`timescale 1ns/1ps
`default_nettype none
`include "mmg_defines.vh"
module mmg_axil_slave #(
  parameter AW = 8
) (
  input  wire          aclk,
  input  wire          aresetn,
  input  wire [AW-1:0] s_awaddr,
  input  wire          s_awvalid,
  output wire          s_awready,
  input  wire [31:0]   s_wdata,
  input  wire [3:0]    s_wstrb,
  input  wire          s_wvalid,
  output wire          s_wready,
  output reg  [1:0]    s_bresp,
  output reg           s_bvalid,
  input  wire          s_bready,
  input  wire [AW-1:0] s_araddr,
  input  wire          s_arvalid,
  output wire          s_arready,
  output reg  [31:0]   s_rdata,
  output reg  [1:0]    s_rresp,
  output reg           s_rvalid,
  input  wire          s_rready,
  output wire          wr_en,
  output wire [AW-1:0] wr_addr,
  output wire [31:0]   wr_data,
  output wire [3:0]    wr_strb,
  input  wire          wr_ok,
  output wire [AW-1:0] rd_addr,
  input  wire [31:0]   rd_data,
  input  wire          rd_ok
);
  reg          aw_full_reg;
  reg          w_full_reg;
  reg [AW-1:0] aw_reg;
  reg [31:0]   w_reg;
  reg [3:0]    strb_reg;

  assign s_awready = !aw_full_reg && !s_bvalid;
  assign s_wready  = !w_full_reg && !s_bvalid;
  assign s_arready = !s_rvalid;
  assign wr_en     = aw_full_reg && w_full_reg && !s_bvalid;
  assign wr_addr   = aw_reg;
  assign wr_data   = w_reg;
  assign wr_strb   = strb_reg;
  assign rd_addr   = s_araddr;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      aw_reg      <= {AW{1'b0}};
      w_reg       <= 32'h00000000;
      strb_reg    <= 4'h0;
      s_bvalid    <= 1'b0;
      s_bresp     <= `MMG_RESP_OKAY;
      s_rvalid    <= 1'b0;
      s_rdata     <= 32'h00000000;
      s_rresp     <= `MMG_RESP_OKAY;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_full_reg <= 1'b1;
        aw_reg      <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        w_full_reg <= 1'b1;
        w_reg      <= s_wdata;
        strb_reg   <= s_wstrb;
      end
      if (wr_en) begin
        aw_full_reg <= 1'b0;
        w_full_reg  <= 1'b0;
        s_bvalid    <= 1'b1;
        s_bresp     <= wr_ok ? `MMG_RESP_OKAY : `MMG_RESP_SLVERR;
      end else if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
      end
      if (s_arvalid && s_arready) begin
        s_rvalid <= 1'b1;
        s_rdata  <= rd_data;
        s_rresp  <= rd_ok ? `MMG_RESP_OKAY : `MMG_RESP_SLVERR;
      end else if (s_rvalid && s_rready) begin
        s_rvalid <= 1'b0;
      end
    end
  end
endmodule // mmg_axil_slave
`default_nettype wire

//--- verilog/mmg_pin_bank.v
// Purpose: General-purpose pins with output enables and sampled inputs
// Assumes: Pin inputs are synchronous to aclk
// Notes: Status packs enable and input level per pin
`timescale 1ns/1ps
`default_nettype none
module mmg_pin_bank #(
  parameter NPIN = 3
) (
  input  wire            aclk,
  input  wire            aresetn,
  input  wire [NPIN-1:0] drive_enable,
  input  wire [NPIN-1:0] drive_value,
  input  wire [NPIN-1:0] pin_in,
  output reg  [NPIN-1:0] pin_out,
  output reg  [NPIN-1:0] pin_oe,
  output wire [2*NPIN-1:0] pin_status
);
  reg [NPIN-1:0] in_reg;
  genvar i;

  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_out <= {NPIN{1'b0}};
      pin_oe  <= {NPIN{1'b0}};
      in_reg  <= {NPIN{1'b0}};
    end else begin
      pin_out <= drive_value;
      pin_oe  <= drive_enable; // [RULE15]
      in_reg  <= pin_in;
    end
  end

  generate
    for (i = 0; i < NPIN; i = i + 1) begin : g_pin
      assign pin_status[2*i]   = pin_oe[i]; // [RULE14]
      assign pin_status[2*i+1] = in_reg[i]; // [RULE14]
    end
  endgenerate
endmodule // mmg_pin_bank
`default_nettype wire

//--- verification/mmg_regs_chk.sv
// Purpose: Concurrent checks on the mmg_regs ports
// Assumes: One clock, synchronous active-low reset
// Notes: Bound to every mmg_regs instance
`timescale 1ns/1ps
`default_nettype none
module mmg_regs_chk #(
  parameter AW = 8
) (
  input wire logic          aclk,
  input wire logic          aresetn,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic          s_axi_arvalid,
  input wire logic          s_axi_arready,
  input wire logic [31:0]   s_axi_rdata,
  input wire logic [1:0]    s_axi_rresp,
  input wire logic          s_axi_rvalid,
  input wire logic          s_axi_rready,
  input wire logic          s_axi_awvalid,
  input wire logic          s_axi_awready,
  input wire logic          s_axi_wvalid,
  input wire logic          s_axi_wready,
  input wire logic          s_axi_bvalid,
  input wire logic [2:0]    primary_phy_kind,
  input wire logic [4:0]    primary_phy_index,
  input wire logic [2:0]    secondary_phy_kind,
  input wire logic [4:0]    secondary_phy_index,
  input wire logic          link_rate_high,
  input wire logic          full_duplex,
  input wire logic          tx_pause_enable,
  input wire logic          half_duplex_rx_full,
  input wire logic          backpressure_on,
  input wire logic          reset_ctrl_select,
  input wire logic          usb_reset_level,
  input wire logic          int_phy_reset_n,
  input wire logic          ext_phy_reset_pin_out
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_w_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  a_phy_word: assert property (s_ar_take ##0 (s_axi_araddr == 8'h64) |=>
    s_axi_rdata[15:0] == {$past(primary_phy_kind), $past(primary_phy_index),
    $past(secondary_phy_kind), $past(secondary_phy_index)}) else $error("phy word wrong");
  a_rate_read: assert property (s_ar_take ##0 (s_axi_araddr == 8'h70) |=>
    s_axi_rdata[4] == $past(link_rate_high)) else $error("link rate bit wrong");
  a_bad_read: assert property (s_ar_take ##0 (s_axi_araddr == 8'h84) |=>
    s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read accepted");
  a_read_answer: assert property (s_ar_take |=> s_axi_rvalid)
    else $error("read answer late");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  a_write_answer: assert property (s_w_take |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_bp_on: assert property ((!full_duplex && tx_pause_enable && half_duplex_rx_full)[*3]
    |-> backpressure_on) else $error("backpressure missing");
  a_bp_off: assert property ((full_duplex || !half_duplex_rx_full)[*3]
    |-> !backpressure_on) else $error("backpressure spurious");
  a_ext_usb: assert property ((!reset_ctrl_select && $stable(usb_reset_level))[*3]
    |-> ext_phy_reset_pin_out == !usb_reset_level) else $error("ext reset not usb");
  a_int_usb: assert property ((!reset_ctrl_select && $stable(usb_reset_level))[*3]
    |-> int_phy_reset_n == !usb_reset_level) else $error("int reset not usb");
endmodule // mmg_regs_chk
bind mmg_regs mmg_regs_chk #(.AW(AW)) mmg_regs_chk_i (.aclk, .aresetn, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .primary_phy_kind, .primary_phy_index, .secondary_phy_kind, .secondary_phy_index,
  .link_rate_high, .full_duplex, .tx_pause_enable, .half_duplex_rx_full, .backpressure_on,
  .reset_ctrl_select, .usb_reset_level, .int_phy_reset_n, .ext_phy_reset_pin_out);
`default_nettype wire

//--- verification/mmg_regs_test.sv
// Purpose: Self-checking bench for the mmg_regs bank
// Assumes: 40 MHz aclk, byte address is index times four
// Notes: Random stimulus from a fixed seed
`timescale 1ns/1ps
`default_nettype none
module mmg_regs_test;
  localparam OK = 2'h0;
  localparam SE = 2'h2;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, w, d;
  logic [3:0]  s_axi_wstrb;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  logic [2:0]  secondary_phy_kind, primary_phy_kind, ext_in;
  logic [4:0]  secondary_phy_index, primary_phy_index;
  logic        link_rate_high, reset_ctrl_select, usb_reset_level, half_duplex_rx_full;
  wire  [2:0]  pin_in, pin_out, pin_oe;
  wire         full_duplex, rx_pause_enable, tx_pause_enable, pause_by_type_only, rx_path_on;
  wire         mii_speed_select, backpressure_continuous, fast_backoff, backpressure_on;
  wire         monitor_only, wake_on_link, wake_on_magic, eeprom_reload, bulkin_error_clear;
  wire         bulkout_error_clear, force_zero_length, int_phy_reset_n, int_phy_powerdown;
  wire         ext_phy_reset_pin_out, ext_phy_reset_pin_oe;
  integer      bad_count, num_checks, seed, i;
  // Pin level seen by the design: its own drive where enabled, else the board
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_in);
  mmg_regs mmg_regs_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .secondary_phy_kind, .secondary_phy_index, .primary_phy_kind,
    .primary_phy_index, .link_rate_high, .reset_ctrl_select, .usb_reset_level,
    .half_duplex_rx_full, .pin_in, .pin_out, .pin_oe, .full_duplex, .rx_pause_enable,
    .tx_pause_enable, .pause_by_type_only, .rx_path_on, .mii_speed_select,
    .backpressure_continuous, .fast_backoff, .backpressure_on, .monitor_only, .wake_on_link,
    .wake_on_magic, .eeprom_reload, .bulkin_error_clear, .bulkout_error_clear,
    .force_zero_length, .int_phy_reset_n, .int_phy_powerdown, .ext_phy_reset_pin_out,
    .ext_phy_reset_pin_oe);
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  function [31:0] pin_st(input [7:0] v, input [2:0] e);
    integer k;
    reg [2:0] oe, lv;
    begin
      oe = {v[4], v[2], v[0]};
      lv = (oe & {v[5], v[3], v[1]}) | (~oe & e);
      pin_st = 32'h0;
      for (k = 0; k < 3; k = k + 1) pin_st[2*k+:2] = {lv[k], oe[k]};
    end
  endfunction
  task check(input [31:0] seen, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] v, input [1:0] er);
    begin
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
        @(posedge aclk);
        if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
        if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      check({30'h0, s_axi_bresp}, {30'h0, er});
    end
  endtask
  task rd(input [7:0] a, input [31:0] ed, input [1:0] er);
    begin
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
        @(posedge aclk);
        if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      check(s_axi_rdata, ed);
      check({30'h0, s_axi_rresp}, {30'h0, er});
    end
  endtask
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  initial begin
    #1000000;
    bad_count = bad_count + 1;
    complete_run;
  end
  initial begin
    seed = 95;
    bad_count = 0;
    num_checks = 0;
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = 0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, link_rate_high, reset_ctrl_select} = 0;
    {usb_reset_level, half_duplex_rx_full, ext_in} = 0;
    s_axi_wstrb = 4'hF;
    {primary_phy_kind, primary_phy_index, secondary_phy_kind, secondary_phy_index} = 16'hAC53;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check({full_duplex, rx_pause_enable, tx_pause_enable, pause_by_type_only, rx_path_on,
      mii_speed_select, backpressure_continuous, fast_backoff}, 8'hE4);
    check({monitor_only, wake_on_link, wake_on_magic, eeprom_reload, pin_oe}, 7'h0);
    check({bulkin_error_clear, bulkout_error_clear, force_zero_length, int_phy_powerdown,
      ext_phy_reset_pin_oe}, 5'h02);
    rd(8'h68, 32'h0236, OK);
    rd(8'h70, 32'h0, OK);
    rd(8'h78, 32'h0, OK);
    rd(8'h64, 32'hAC53, OK);
    $display("test reset done");
    for (i = 0; i < 10; i = i + 1) begin
      w = (i == 0) ? 32'h1BB6 : (i == 1) ? 32'h24 : ($random(seed) & 32'hFFB2) | 32'h4;
      half_duplex_rx_full <= (i < 2) | 1'($random(seed));
      wr(8'h6C, w, OK);
      repeat (3) @(posedge aclk);
      check({full_duplex, rx_pause_enable, tx_pause_enable, pause_by_type_only, rx_path_on,
        mii_speed_select, backpressure_continuous, fast_backoff},
        {w[1], w[4], w[5], w[7], w[8], w[9], w[11], w[12]});
      check(backpressure_on, !w[1] & w[5] & half_duplex_rx_full);
      d = w & 32'h1BB6;
      rd(8'h68, d, OK);
    end
    $display("test medium done");
    for (i = 0; i < 8; i = i + 1) begin
      link_rate_high <= i[0] ^ i[2];
      wr(8'h74, i, OK);
      repeat (3) @(posedge aclk);
      check({monitor_only, wake_on_link, wake_on_magic}, {i[0], i[1], i[2]});
      rd(8'h70, {i[0] ^ i[2], 1'b0, i[2:0]}, OK);
    end
    $display("test monitor done");
    for (i = 0; i < 6; i = i + 1) begin
      w = (i == 0) ? 32'hBF : $random(seed) & 32'hBF;
      ext_in <= 3'($random(seed));
      wr(8'h7C, w, OK);
      repeat (4) @(posedge aclk);
      check(pin_oe, {w[4], w[2], w[0]});
      check(pin_out & pin_oe, {w[5], w[3], w[1]} & {w[4], w[2], w[0]});
      check(eeprom_reload, w[7]);
      rd(8'h78, pin_st(w[7:0], ext_in), OK);
    end
    $display("test pins done");
    for (i = 0; i < 8; i = i + 1) begin
      w = (i == 0) ? 32'h7F : (i == 1) ? 32'h0 : $random(seed) & 32'h7F;
      reset_ctrl_select <= i[0];
      usb_reset_level <= 1'($random(seed));
      wr(8'h80, w, OK);
      repeat (3) @(posedge aclk);
      check({bulkin_error_clear, bulkout_error_clear, force_zero_length, int_phy_powerdown},
        {w[0], w[1], w[4], w[6]});
      check(ext_phy_reset_pin_oe, !w[2]);
      if (!w[2]) check(ext_phy_reset_pin_out, i[0] ? w[3] : !usb_reset_level);
      check(int_phy_reset_n, i[0] ? w[5] : !usb_reset_level);
    end
    $display("test soft reset done");
    {primary_phy_kind, primary_phy_index, secondary_phy_kind, secondary_phy_index}
      <= 16'($random(seed));
    rd(8'h6C, 32'h0, SE);
    rd(8'h84, 32'h0, SE);
    wr(8'h68, 32'hFFFF, SE);
    wr(8'h84, 32'h1, SE);
    rd(8'h68, d, OK);
    s_axi_wstrb <= 4'h2;
    wr(8'h6C, 32'h0, OK);
    rd(8'h68, d & 32'hFF, OK);
    rd(8'h64, {16'h0, primary_phy_kind, primary_phy_index, secondary_phy_kind,
      secondary_phy_index}, OK);
    $display("test refusals done");
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h68, 32'h0236, OK);
    check({int_phy_powerdown, ext_phy_reset_pin_oe, mii_speed_select, bulkin_error_clear},
      4'hA);
    $display("test second reset done");
    complete_run;
  end
endmodule // mmg_regs_test
`default_nettype wire
